//--- hw/tec_top.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Overflow at FF raises irq and reloads
// - Count exactly one per selected tick
// - Write while disabled loads counter too
// - Write while enabled updates preload only
// - Read returns live counter value
// - Mode 01 event, 10 timer, 11 pulse
// - Count only while enable bit set
// - Clock source bit picks system/sub clock
// - Prescale divides by two to the code
// - Internal clock timer/pulse, pin for event
// - Source and prescale ignored for pin counting
// - Event edge: 0 rising, 1 falling
// - Pulse edge picks start and stop polarity
// - Pin function 11 selects chip select
// - Pulse mode waits for start edge
// - Pulse end clears enable bit
// - Timer counts divided clock falling edges
module tec_top
    import tec_pkg::*;
(
    input  wire logic        CLOCK_IN,
    input  wire logic        SRST_IN,
    input  wire logic        CE_IN,
    input  wire logic        SUB_TICK_IN,
    input  wire logic        TIMER_PIN_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [11:0] PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    input  wire logic [3:0]  PSTRB_IN,
    output logic [31:0]      PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    output logic             OVERFLOW_OUT,
    output logic             TIMER_INPUT_ROUTED_OUT,
    output logic             SERIAL_CHIP_SELECT_OUT
);
    logic [7:0]  count_reg, count_next;
    logic [7:0]  preload_reg, preload_next;
    logic [7:0]  control_reg, control_next;
    logic [1:0]  pinfunc_reg, pinfunc_next;
    logic        running_reg, running_next;
    logic        ovf_reg, ovf_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        sub_s1_reg, sub_s2_reg, sub_s3_reg;

    logic        pin_raw, pin_level, pin_rise, pin_fall, raw_rise, raw_fall, pin_routed;
    logic        base_tick, int_tick, step, access, wr, rd;
    logic        addr_ok, start_edge, stop_edge;
    logic [1:0]  mode;
    logic        enable, edge_sel;

    assign mode     = control_reg[TEC_MODE_HI:TEC_MODE_LO];
    assign enable   = control_reg[TEC_EN_BIT];
    assign edge_sel = control_reg[TEC_EDGE_BIT];

    // Pin is always synchronised; only its edges are withheld from the timer in chip-select role
    assign pin_raw    = TIMER_PIN_IN;
    assign pin_routed = (pinfunc_reg != TEC_PIN_SCS);
    assign pin_rise   = pin_routed & raw_rise;
    assign pin_fall   = pin_routed & raw_fall;
    assign TIMER_INPUT_ROUTED_OUT = pin_routed;
    assign SERIAL_CHIP_SELECT_OUT = ~pin_routed & pin_level;

    tec_sync_edge u_sync (
        .CLOCK_IN  (CLOCK_IN),
        .SRST_IN   (SRST_IN),
        .ce_in     (CE_IN),
        .pin_in    (pin_raw),
        .level_out (pin_level),
        .rise_out  (raw_rise),
        .fall_out  (raw_fall)
    );

    // Sub clock tick is a foreign-domain level: sync then edge detect
    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            sub_s1_reg <= 1'b0;
            sub_s2_reg <= 1'b0;
            sub_s3_reg <= 1'b0;
        end else if (CE_IN) begin
            sub_s1_reg <= SUB_TICK_IN;
            sub_s2_reg <= sub_s1_reg;
            sub_s3_reg <= sub_s2_reg;
        end
    end

    assign base_tick = control_reg[TEC_CSRC_BIT] ? (sub_s3_reg & ~sub_s2_reg) : 1'b1;

    tec_prescaler u_psc (
        .CLOCK_IN     (CLOCK_IN),
        .SRST_IN      (SRST_IN),
        .ce_in        (CE_IN),
        .base_tick_in (base_tick),
        .psc_in       (control_reg[TEC_PSC_HI:0]),
        .tick_out     (int_tick)
    );

    // Pulse mode start and stop edges
    assign start_edge = edge_sel ? pin_rise : pin_fall;
    assign stop_edge  = edge_sel ? pin_fall : pin_rise;

    always_comb begin
        unique case (mode)
            TEC_MODE_EVENT: step = enable & (edge_sel ? pin_fall : pin_rise);
            TEC_MODE_TIMER: step = enable & int_tick;
            TEC_MODE_PULSE: step = enable & running_reg & ~stop_edge & int_tick;
            TEC_MODE_UNUSED: step = 1'b0;
        endcase
    end

    // APB decode: zero wait states, unmapped addresses answer with an error
    assign access  = CE_IN & PSEL_IN & PENABLE_IN;
    assign addr_ok = (PADDR_IN == TEC_ADDR_COUNT) | (PADDR_IN == TEC_ADDR_CONTROL) |
                     (PADDR_IN == TEC_ADDR_PINFUNC);
    assign wr      = access & PWRITE_IN & addr_ok & PSTRB_IN[0];
    assign rd      = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;

    always_comb begin
        count_next   = count_reg;
        preload_next = preload_reg;
        control_next = control_reg;
        pinfunc_next = pinfunc_reg;
        running_next = running_reg;
        ovf_next     = 1'b0;
        rdata_next   = rdata_reg;
        if (step) begin
            if (count_reg == TEC_COUNT_FULL) begin
                count_next = preload_reg;
                ovf_next   = 1'b1;
            end else begin
                count_next = count_reg + 8'h01;
            end
        end
        if (mode == TEC_MODE_PULSE && enable) begin
            if (!running_reg && start_edge) begin
                running_next = 1'b1;
            end else if (running_reg && stop_edge) begin
                running_next = 1'b0;
                control_next[TEC_EN_BIT] = 1'b0;
            end
        end else begin
            running_next = 1'b0;
        end
        if (wr && PADDR_IN == TEC_ADDR_COUNT) begin
            preload_next = PWDATA_IN[7:0];
            if (!enable) begin
                count_next = PWDATA_IN[7:0];
            end
        end
        if (wr && PADDR_IN == TEC_ADDR_CONTROL) begin
            control_next = PWDATA_IN[7:0];
            running_next = 1'b0;
        end
        if (wr && PADDR_IN == TEC_ADDR_PINFUNC) begin
            pinfunc_next = PWDATA_IN[1:0];
        end
        if (rd) begin
            unique case (PADDR_IN)
                TEC_ADDR_COUNT:   rdata_next = {24'h000000, count_reg};
                TEC_ADDR_CONTROL: rdata_next = {24'h000000, control_reg};
                TEC_ADDR_PINFUNC: rdata_next = {30'h00000000, pinfunc_reg};
                default:          rdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            count_reg   <= TEC_COUNT_RST;
            preload_reg <= TEC_COUNT_RST;
            control_reg <= TEC_CONTROL_RST;
            pinfunc_reg <= TEC_PINFUNC_RST;
            running_reg <= 1'b0;
            ovf_reg     <= 1'b0;
            rdata_reg   <= 32'h00000000;
        end else if (CE_IN) begin
            count_reg   <= count_next;
            preload_reg <= preload_next;
            control_reg <= control_next;
            pinfunc_reg <= pinfunc_next;
            running_reg <= running_next;
            ovf_reg     <= ovf_next;
            rdata_reg   <= rdata_next;
        end
    end

    assign PRDATA_OUT   = rdata_reg;
    assign PREADY_OUT   = 1'b1;
    assign PSLVERR_OUT  = access & ~addr_ok;
    assign OVERFLOW_OUT = ovf_reg;

    // Overflow behaviour is built from one step at full count
    sequence full_step_s;
        CE_IN && step && count_reg == TEC_COUNT_FULL;
    endsequence

    sequence reload_s;
        count_reg == $past(preload_reg);
    endsequence

    overflow_reload_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        full_step_s |=> reload_s)
        else $error("overflow did not reload preload");

    overflow_pulse_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        full_step_s |=> ovf_reg)
        else $error("overflow did not raise request");
    count_step_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        CE_IN && step && count_reg != TEC_COUNT_FULL && !wr |=> count_reg == $past(count_reg) + 8'h01)
        else $error("counter did not step by one");
    idle_write_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        wr && PADDR_IN == TEC_ADDR_COUNT && !enable |=> count_reg == $past(PWDATA_IN[7:0]))
        else $error("disabled write missed counter");
    run_write_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        wr && PADDR_IN == TEC_ADDR_COUNT && enable && !step |=> count_reg == $past(count_reg))
        else $error("running write touched counter");
    read_live_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        CE_IN && rd && PADDR_IN == TEC_ADDR_COUNT |=> rdata_reg[7:0] == $past(count_reg))
        else $error("read did not return live count");
    hold_disabled_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        CE_IN && !enable && !wr |=> $stable(count_reg))
        else $error("counter moved while disabled");
    unused_hold_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        CE_IN && mode == TEC_MODE_UNUSED |=> !ovf_reg)
        else $error("overflow in unused mode");
    pulse_stop_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        CE_IN && mode == TEC_MODE_PULSE && enable && running_reg && stop_edge && !wr |=> !enable)
        else $error("pulse end did not clear enable");
    pulse_wait_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        mode == TEC_MODE_PULSE && !running_reg |-> !step)
        else $error("pulse counted before start edge");

    // Pulse measurement start
    sequence pulse_start_s;
        CE_IN && mode == TEC_MODE_PULSE && enable && !running_reg && start_edge && !wr;
    endsequence

    pulse_start_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        pulse_start_s |=> running_reg)
        else $error("start edge did not begin pulse count");

    pulse_arm_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        CE_IN && !running_reg && !start_edge |=> !running_reg)
        else $error("pulse count began without start edge");

    pulse_tick_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        mode == TEC_MODE_PULSE && step |-> int_tick)
        else $error("pulse count without internal tick");

    // Event and timer counting
    event_pin_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        mode == TEC_MODE_EVENT && step |-> (pin_rise || pin_fall))
        else $error("event count without pin edge");

    event_step_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        CE_IN && mode == TEC_MODE_EVENT && enable && (edge_sel ? pin_fall : pin_rise) &&
        count_reg != TEC_COUNT_FULL && !wr |=> count_reg == $past(count_reg) + 8'h01)
        else $error("selected pin edge not counted");

    event_ignore_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        CE_IN && mode == TEC_MODE_EVENT && !(edge_sel ? pin_fall : pin_rise) && !wr |=> $stable(count_reg))
        else $error("other pin edge was counted");

    timer_step_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        CE_IN && mode == TEC_MODE_TIMER && enable && int_tick && count_reg != TEC_COUNT_FULL && !wr
        |=> count_reg == $past(count_reg) + 8'h01)
        else $error("divided tick not counted");

    timer_idle_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        CE_IN && mode == TEC_MODE_TIMER && !int_tick && !wr |=> $stable(count_reg))
        else $error("timer moved between ticks");

    overflow_only_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        CE_IN && !(step && count_reg == TEC_COUNT_FULL) |=> !ovf_reg)
        else $error("overflow request without overflow");

    unused_step_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        mode == TEC_MODE_UNUSED |-> !step)
        else $error("count step in unused mode");

    // Clock source and pin routing
    sys_base_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        !control_reg[TEC_CSRC_BIT] |-> base_tick)
        else $error("system clock base tick missing");

    sub_base_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        control_reg[TEC_CSRC_BIT] && base_tick && $past(CE_IN) |-> $past(sub_s2_reg) && !sub_s2_reg)
        else $error("sub clock tick without falling edge");

    pin_gate_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        pinfunc_reg == TEC_PIN_SCS |-> !pin_rise && !pin_fall && !TIMER_INPUT_ROUTED_OUT)
        else $error("chip select pin reached the timer");

    cs_off_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        pinfunc_reg != TEC_PIN_SCS |-> !SERIAL_CHIP_SELECT_OUT)
        else $error("chip select driven in timer role");
endmodule
`default_nettype wire

//--- hw/tec_pkg.sv
package tec_pkg;
    // Register byte addresses on the APB side
    localparam logic [11:0] TEC_ADDR_COUNT   = 12'h000;
    localparam logic [11:0] TEC_ADDR_CONTROL = 12'h004;
    localparam logic [11:0] TEC_ADDR_PINFUNC = 12'h008;
    // Control field positions
    localparam int TEC_MODE_HI  = 7;
    localparam int TEC_MODE_LO  = 6;
    localparam int TEC_CSRC_BIT = 5;
    localparam int TEC_EN_BIT   = 4;
    localparam int TEC_EDGE_BIT = 3;
    localparam int TEC_PSC_HI   = 2;
    // Reset values
    localparam logic [7:0] TEC_COUNT_RST   = 8'h00;
    localparam logic [7:0] TEC_CONTROL_RST = 8'h08;
    localparam logic [1:0] TEC_PINFUNC_RST = 2'h0;
    localparam logic [7:0] TEC_COUNT_FULL  = 8'hFF;
    // Mode codes
    localparam logic [1:0] TEC_MODE_UNUSED = 2'h0;
    localparam logic [1:0] TEC_MODE_EVENT  = 2'h1;
    localparam logic [1:0] TEC_MODE_TIMER  = 2'h2;
    localparam logic [1:0] TEC_MODE_PULSE  = 2'h3;
    localparam logic [1:0] TEC_PIN_SCS     = 2'h3;
    localparam int         TEC_SYNC_STAGES = 2;
endpackage

//--- hw/tec_sync_edge.sv
`timescale 1ns/1ps
`default_nettype none
module tec_sync_edge
    import tec_pkg::*;
(
    input  wire logic CLOCK_IN,
    input  wire logic SRST_IN,
    input  wire logic ce_in,
    input  wire logic pin_in,
    output logic      level_out,
    output logic      rise_out,
    output logic      fall_out
);
    logic       s1_reg, s1_next;
    logic       s2_reg, s2_next;
    logic       s3_reg, s3_next;

    always_comb begin
        s1_next = pin_in;
        s2_next = s1_reg;
        s3_next = s2_reg;
    end

    // Only s2 and s3 feed edge logic; s1 may be metastable
    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else if (ce_in) begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
        end
    end

    assign level_out = s2_reg;
    assign rise_out  = ce_in & s2_reg & ~s3_reg;
    assign fall_out  = ce_in & ~s2_reg & s3_reg;

    sync_rise_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        rise_out && $past(ce_in) && $past(ce_in, 2) |-> $past(pin_in, 2))
        else $error("rise edge without synchronised high");

    sync_fall_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        fall_out && $past(ce_in) && $past(ce_in, 2) |-> !$past(pin_in, 2))
        else $error("fall edge without synchronised low");
endmodule
`default_nettype wire

//--- hw/tec_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module tec_prescaler
    import tec_pkg::*;
#(
    parameter int DIV_BITS = 7
) (
    input  wire logic       CLOCK_IN,
    input  wire logic       SRST_IN,
    input  wire logic       ce_in,
    input  wire logic       base_tick_in,
    input  wire logic [2:0] psc_in,
    output logic            tick_out
);
    logic [DIV_BITS-1:0] cnt_reg, cnt_next;
    logic [DIV_BITS-1:0] mask;

    always_comb begin
        cnt_next = cnt_reg;
        if (base_tick_in) begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            cnt_reg <= '0;
        end else if (ce_in) begin
            cnt_reg <= cnt_next;
        end
    end

    // Divide by 2**psc: tick when low psc bits roll over (falling edge of divided clock)
    assign mask     = DIV_BITS'((1 << psc_in) - 1);
    assign tick_out = ce_in & base_tick_in & ((cnt_reg & mask) == mask);

    tec_div_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        (psc_in == 3'h0 && base_tick_in && ce_in) |-> tick_out)
        else $error("undivided base tick not passed");
endmodule
`default_nettype wire

//--- verification/tec_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module tec_pin_model #(
    parameter int SUB_HALF = 4
) (
    input  wire logic clk_in,
    input  wire logic level_in,
    output logic      pin_out,
    output logic      sub_out
);
    int cnt;

    initial begin
        pin_out = 1'b0;
        sub_out = 1'b0;
        cnt     = 0;
    end

    // Pin follows the bench one edge late; callers hold each level well over two cycles
    // Sub clock runs free, as an oscillator would, with a falling edge every 2*SUB_HALF cycles
    always @(posedge clk_in) begin
        pin_out <= level_in;
        if (cnt == SUB_HALF - 1) begin
            cnt     <= 0;
            sub_out <= ~sub_out;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule
`default_nettype wire

//--- verification/tec_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module tec_top_test;
    import tec_pkg::*;
    logic        clk = 1'b0;
    logic        srst, ce, psel, penable, pwrite, pin_req, pin, sub, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, r, c1;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready, pslverr, ovf, routed, cs;
    int          miscompares, tests_run, seed, ovf_seen, m, o0, w, len;

    tec_pin_model #(.SUB_HALF(4)) partner (.clk_in(clk), .level_in(pin_req), .pin_out(pin), .sub_out(sub));

    tec_top dut (.CLOCK_IN(clk), .SRST_IN(srst), .CE_IN(ce), .SUB_TICK_IN(sub), .TIMER_PIN_IN(pin),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PSTRB_IN(pstrb), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .OVERFLOW_OUT(ovf), .TIMER_INPUT_ROUTED_OUT(routed), .SERIAL_CHIP_SELECT_OUT(cs));

    initial forever #2.5 clk = ~clk;

    always @(posedge clk) if (ovf === 1'b1) ovf_seen++;

    task automatic summarize;
        if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) miscompares++;
        r       = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic in_range(input logic [31:0] v, input int lo, input int hi);
        check({31'h0, (v >= lo && v <= hi)}, 32'h1);
    endtask

    initial begin
        #(5 * 60000);
        miscompares++;
        summarize();
    end

    initial begin
        seed = 15;
        {srst, ce, psel, penable, pwrite, pin_req} = 6'b110000;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'hF;
        wait_n(6);
        srst <= 1'b0;
        apb(0, TEC_ADDR_COUNT, 0);   check(r, 32'h00);
        apb(0, TEC_ADDR_CONTROL, 0); check(r, 32'h08);
        apb(0, TEC_ADDR_PINFUNC, 0); check(r, 32'h00);
        apb(0, 12'h00C, 0);          check(r, 32'h0); check({31'h0, err}, 32'h1);
        m = $random(seed) & 255;
        apb(1, TEC_ADDR_CONTROL, 8'h00);
        apb(1, TEC_ADDR_COUNT, m[7:0]);
        apb(0, TEC_ADDR_COUNT, 0);   check(r, m);
        pstrb <= 4'h0;
        apb(1, TEC_ADDR_COUNT, ~m[7:0]);
        pstrb <= 4'hF;
        // Unused mode with enable set: pin and internal ticks must not move the count
        o0 = ovf_seen;
        apb(1, TEC_ADDR_CONTROL, 8'h10);
        repeat (3) begin pin_req <= 1'b1; wait_n(6); pin_req <= 1'b0; wait_n(6); end
        apb(0, TEC_ADDR_COUNT, 0);   check(r, m);
        check(ovf_seen - o0, 0);
        for (int e = 0; e < 2; e++) begin
            m = 0;
            apb(1, TEC_ADDR_CONTROL, 8'h00);
            apb(1, TEC_ADDR_COUNT, 8'h00);
            apb(1, TEC_ADDR_CONTROL, {2'b01, 1'b1, 1'b1, e[0], 3'b111});
            for (int k = 0; k < 3; k++) begin
                pin_req <= 1'b1; wait_n(8); m += (e == 0);
                apb(0, TEC_ADDR_COUNT, 0); check(r, m);
                pin_req <= 1'b0; wait_n(8); m += (e == 1);
                apb(0, TEC_ADDR_COUNT, 0); check(r, m);
            end
        end
        apb(1, TEC_ADDR_CONTROL, 8'h00);
        apb(1, TEC_ADDR_COUNT, 8'hFE);
        apb(1, TEC_ADDR_CONTROL, 8'h50);
        apb(1, TEC_ADDR_COUNT, 8'h00);
        apb(0, TEC_ADDR_COUNT, 0);   check(r, 32'hFE);
        o0 = ovf_seen;
        pin_req <= 1'b1; wait_n(8); pin_req <= 1'b0; wait_n(8);
        apb(0, TEC_ADDR_COUNT, 0);   check(r, 32'hFF);
        pin_req <= 1'b1; wait_n(8); pin_req <= 1'b0; wait_n(8);
        apb(0, TEC_ADDR_COUNT, 0);   check(r, 32'h00);
        check(ovf_seen - o0, 1);
        // Internal clock: 20 expected ticks for every system clock prescale code and for sub clock prescale codes 0-3
        o0 = ovf_seen;
        for (int i = 0; i < 12; i++) begin
            w = (i < 8) ? (20 << (i & 7)) : (160 << (i & 7));
            apb(1, TEC_ADDR_CONTROL, 8'h00);
            apb(1, TEC_ADDR_COUNT, 8'h00);
            apb(1, TEC_ADDR_CONTROL, {2'b10, i >= 8, 1'b1, 1'b0, i[2:0]});
            wait_n(w);
            apb(1, TEC_ADDR_CONTROL, {2'b10, i >= 8, 1'b0, 1'b0, i[2:0]});
            apb(0, TEC_ADDR_COUNT, 0);   in_range(r, 19, 24);
            c1 = r;
            wait_n(30);
            apb(0, TEC_ADDR_COUNT, 0);   check(r, c1);
        end
        check(ovf_seen - o0, 0);
        // Clock enable low freezes the counter: only the three edges of the stopping write count
        apb(1, TEC_ADDR_CONTROL, 8'h00);
        apb(1, TEC_ADDR_COUNT, 8'h00);
        apb(1, TEC_ADDR_CONTROL, 8'h90);
        ce <= 1'b0;
        wait_n(20);
        ce <= 1'b1;
        apb(1, TEC_ADDR_CONTROL, 8'h00);
        apb(0, TEC_ADDR_COUNT, 0);   check(r, 32'h03);
        for (int e = 0; e < 2; e++) begin
            len = 20 + ($random(seed) & 15);
            apb(1, TEC_ADDR_CONTROL, 8'h00);
            pin_req <= ~e[0];
            wait_n(8);
            apb(1, TEC_ADDR_COUNT, 8'h00);
            apb(1, TEC_ADDR_CONTROL, {2'b11, 1'b0, 1'b1, e[0], 3'b000});
            wait_n(20);
            apb(0, TEC_ADDR_COUNT, 0);   check(r, 32'h0);
            pin_req <= e[0]; wait_n(len); pin_req <= ~e[0]; wait_n(10);
            apb(0, TEC_ADDR_COUNT, 0);   in_range(r, len - 2, len + 2);
            c1 = r;
            apb(0, TEC_ADDR_CONTROL, 0); check({31'h0, r[4]}, 32'h0);
            pin_req <= e[0]; wait_n(12); pin_req <= ~e[0]; wait_n(10);
            apb(0, TEC_ADDR_COUNT, 0);   check(r, c1);
        end
        for (int c = 0; c < 8; c++) begin
            apb(1, TEC_ADDR_PINFUNC, c[1:0]);
            pin_req <= c[2];
            wait_n(8);
            check({31'h0, routed}, {31'h0, c[1:0] != 2'h3});
            check({31'h0, cs}, {31'h0, c[1:0] == 2'h3 && c[2]});
        end
        summarize();
    end
endmodule
`default_nettype wire
